// File: core/rmp_pkg.sv
// Constants and types shared by the RMII port pin logic
package rmp_pkg;
   localparam logic [7:0] SFD_BYTE           = 8'hab;
   localparam logic [1:0] DIBIT_IDLE         = 2'h0;
   localparam logic [2:0] OPMODE_DEFAULT     = 3'h7;
   localparam logic       MGMT_ADDR0_DEFAULT = 1'h0;
   localparam int         PULL_RXD0          = 0;
   localparam int         PULL_RXD1          = 1;
   localparam int         PULL_CRS_DV        = 2;
   localparam int         PULL_RXER          = 3;
   localparam int         PULL_TXEN          = 4;
   localparam logic [4:0] PIN_PULL_DEFAULT   = 5'h07;
   typedef enum logic [1:0] {
      RX_IDLE,
      RX_HUNT,
      RX_PASS
   } rmp_rx_e;
endpackage

// File: core/rmp_strap_latch.sv
// Strap capture for the shared receive pins
`timescale 1ns/1ps
module rmp_strap_latch (
   input  wire logic i_core_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_capture,
   input  wire logic i_rxd0_pin,
   input  wire logic i_rxd1_pin,
   input  wire logic i_crs_dv_pin,
   input  wire logic i_rxer_pin,
   output logic      o_opmode_strap_bit0,
   output logic      o_opmode_strap_bit1,
   output logic      o_opmode_strap_bit2,
   output logic      o_mgmt_addr_strap_bit0
);
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_opmode_strap_bit0    <= rmp_pkg::OPMODE_DEFAULT[0];
         o_opmode_strap_bit1    <= rmp_pkg::OPMODE_DEFAULT[1];
         o_opmode_strap_bit2    <= rmp_pkg::OPMODE_DEFAULT[2];
         o_mgmt_addr_strap_bit0 <= rmp_pkg::MGMT_ADDR0_DEFAULT;
      end else if (i_capture) begin
         o_opmode_strap_bit0    <= i_rxd0_pin;
         o_opmode_strap_bit1    <= i_rxd1_pin;
         o_opmode_strap_bit2    <= i_crs_dv_pin;
         o_mgmt_addr_strap_bit0 <= i_rxer_pin;
      end
   end

   a_strap_mode: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      i_capture |=> {o_opmode_strap_bit2, o_opmode_strap_bit1,
                     o_opmode_strap_bit0} == $past({i_crs_dv_pin,
                     i_rxd1_pin, i_rxd0_pin}))
      else $error("Mode straps not taken from receive pins");

   a_strap_addr: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      i_capture |=> o_mgmt_addr_strap_bit0 == $past(i_rxer_pin))
      else $error("Address strap not taken from error pin");

   a_strap_hold: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      !i_capture |=> $stable({o_opmode_strap_bit2, o_opmode_strap_bit1,
                     o_opmode_strap_bit0, o_mgmt_addr_strap_bit0}))
      else $error("Straps changed outside reset release");
endmodule

// File: core/rmp_rmii_port.sv
// RMII receive/transmit pin logic of the PHY with reset-time straps
// Overview of operation
// - Flag error detected anywhere in current frame
// - Carrier/data valid high while medium busy
// - 10M: data low until SFD, carrier immediate
// - 10M half duplex: no transmit echo on receive
// - Receive data, carrier pins strap mode bits
// - Error pin straps management address bit 0
// - Fixed pulls: data/carrier high, error/enable low
// - External reset is active low
`timescale 1ns/1ps
module rmp_rmii_port (
   input  wire logic       i_core_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_ext_reset_n,
   input  wire logic       i_txd0,
   input  wire logic       i_txd1,
   input  wire logic       i_txen,
   input  wire logic       i_rx_active,
   input  wire logic [1:0] i_rx_dibit,
   input  wire logic       i_rx_err,
   input  wire logic       i_speed_10,
   input  wire logic       i_half_duplex,
   input  wire logic       i_rxd0_pin,
   input  wire logic       i_rxd1_pin,
   input  wire logic       i_crs_dv_pin,
   input  wire logic       i_rxer_pin,
   output logic [1:0]      o_tx_dibit,
   output logic            o_tx_valid,
   output logic            o_rxd0,
   output logic            o_rxd0_oe_n,
   output logic            o_rxd1,
   output logic            o_rxd1_oe_n,
   output logic            o_crs_dv,
   output logic            o_crs_dv_oe_n,
   output logic            o_rxer,
   output logic            o_rxer_oe_n,
   output logic [4:0]      o_pin_pull,
   output logic            o_in_reset,
   output logic            o_opmode_strap_bit0,
   output logic            o_opmode_strap_bit1,
   output logic            o_opmode_strap_bit2,
   output logic            o_mgmt_addr_strap_bit0
);
   rmp_pkg::rmp_rx_e state_q;
   rmp_pkg::rmp_rx_e state_d;
   logic [7:0]       hunt_q;
   logic             oe_n_q;

   wire        live          = ~o_in_reset;
   wire        strap_capture = o_in_reset & i_ext_reset_n;
   wire        echo_block    = i_speed_10 & i_half_duplex & i_txen;
   // Delimiter bits gather oldest first, line 0 before line 1 in a dibit
   wire [7:0]  hunt_byte     = {hunt_q[5:0], i_rx_dibit[0], i_rx_dibit[1]};
   wire        sfd_hit       = (hunt_byte == rmp_pkg::SFD_BYTE);
   wire        pass_now      = (state_d == rmp_pkg::RX_PASS) & ~echo_block;
   wire [1:0]  rxd_d         = pass_now ? i_rx_dibit : rmp_pkg::DIBIT_IDLE;
   wire [7:0]  hunt_d        = i_rx_active ? hunt_byte : 8'h00;

   // Receive framing: 10M hunts for the SFD, 100M passes straight through
   always_comb begin
      state_d = state_q;
      case (state_q)
         rmp_pkg::RX_IDLE: begin
            if (i_rx_active) begin
               if (i_speed_10 && !sfd_hit) begin
                  state_d = rmp_pkg::RX_HUNT;
               end else begin
                  state_d = rmp_pkg::RX_PASS;
               end
            end
         end
         rmp_pkg::RX_HUNT: begin
            if (!i_rx_active) begin
               state_d = rmp_pkg::RX_IDLE;
            end else if (sfd_hit) begin
               state_d = rmp_pkg::RX_PASS;
            end
         end
         rmp_pkg::RX_PASS: begin
            if (!i_rx_active) begin
               state_d = rmp_pkg::RX_IDLE;
            end
         end
         default: state_d = rmp_pkg::RX_IDLE;
      endcase
      if (!live) begin
         state_d = rmp_pkg::RX_IDLE;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= rmp_pkg::RX_IDLE;
         hunt_q  <= 8'h00;
      end else begin
         state_q <= state_d;
         hunt_q  <= hunt_d;
      end
   end

   // Reset pin and pin direction; pins stay released while straps settle
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_in_reset <= 1'h1;
         oe_n_q     <= 1'h1;
         o_pin_pull <= rmp_pkg::PIN_PULL_DEFAULT;
      end else begin
         o_in_reset <= ~i_ext_reset_n;
         oe_n_q     <= ~(i_ext_reset_n & ~strap_capture & live);
         o_pin_pull <= rmp_pkg::PIN_PULL_DEFAULT;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rxd0        <= 1'h0;
         o_rxd1        <= 1'h0;
         o_crs_dv      <= 1'h0;
         o_rxer        <= 1'h0;
         o_rxd0_oe_n   <= 1'h1;
         o_rxd1_oe_n   <= 1'h1;
         o_crs_dv_oe_n <= 1'h1;
         o_rxer_oe_n   <= 1'h1;
         o_tx_dibit    <= 2'h0;
         o_tx_valid    <= 1'h0;
      end else begin
         o_rxd0        <= rxd_d[0];
         o_rxd1        <= rxd_d[1];
         o_crs_dv      <= i_rx_active & live;
         o_rxer        <= i_rx_err & i_rx_active & live;
         o_rxd0_oe_n   <= oe_n_q;
         o_rxd1_oe_n   <= oe_n_q;
         o_crs_dv_oe_n <= oe_n_q;
         o_rxer_oe_n   <= oe_n_q;
         o_tx_dibit    <= {i_txd1, i_txd0};
         o_tx_valid    <= i_txen & live;
      end
   end

   rmp_strap_latch u_strap (
      .i_core_clk             (i_core_clk),
      .i_sys_rst              (i_sys_rst),
      .i_capture              (strap_capture),
      .i_rxd0_pin             (i_rxd0_pin),
      .i_rxd1_pin             (i_rxd1_pin),
      .i_crs_dv_pin           (i_crs_dv_pin),
      .i_rxer_pin             (i_rxer_pin),
      .o_opmode_strap_bit0    (o_opmode_strap_bit0),
      .o_opmode_strap_bit1    (o_opmode_strap_bit1),
      .o_opmode_strap_bit2    (o_opmode_strap_bit2),
      .o_mgmt_addr_strap_bit0 (o_mgmt_addr_strap_bit0)
   );

   a_rx_bit_order: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (live && i_rx_active && !i_speed_10 && !echo_block) |=>
      {o_rxd1, o_rxd0} == $past(i_rx_dibit))
      else $error("Receive dibit not on expected lines");

   a_rx_err_flag: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (live && i_rx_active && i_rx_err) |=> o_rxer ##0 o_crs_dv)
      else $error("Receive error not flagged in frame");

   a_carrier_valid: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      live |=> (o_crs_dv == $past(i_rx_active)))
      else $error("Carrier indication does not follow medium");

   a_sfd_hold_low: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (live && i_speed_10 && state_q != rmp_pkg::RX_PASS && i_rx_active
       && !sfd_hit) |=> (o_crs_dv && !o_rxd0 && !o_rxd1))
      else $error("Receive data not held low before delimiter");

   a_sfd_pass: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (live && i_speed_10 && i_rx_active && sfd_hit && !echo_block) |=>
      {o_rxd1, o_rxd0} == $past(i_rx_dibit))
      else $error("Data not passed once delimiter seen");

   a_hunt_clear: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      !i_rx_active |=> (hunt_q == 8'h00))
      else $error("Delimiter search not restarted at idle");

   a_no_echo: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      echo_block |=> (!o_rxd0 && !o_rxd1))
      else $error("Transmit echoed onto receive data");

   a_pull_fixed: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      o_pin_pull[rmp_pkg::PULL_RXD0] && o_pin_pull[rmp_pkg::PULL_RXD1]
      && o_pin_pull[rmp_pkg::PULL_CRS_DV]
      && !o_pin_pull[rmp_pkg::PULL_RXER]
      && !o_pin_pull[rmp_pkg::PULL_TXEN])
      else $error("Pin pull pattern wrong");

   a_held_reset: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      !i_ext_reset_n |=> o_in_reset ##1 (o_rxd0_oe_n && o_crs_dv_oe_n
      && !o_crs_dv && !o_tx_valid))
      else $error("Port active while external reset low");

   a_pins_release: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      strap_capture |=> oe_n_q ##1 o_rxer_oe_n)
      else $error("Pins driven during strap capture");

   a_tx_follow: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      live |=> (o_tx_dibit == $past({i_txd1, i_txd0})))
      else $error("Transmit dibit not carried on both lines");

   a_tx_enable: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      live |=> (o_tx_valid == $past(i_txen)))
      else $error("Transmit enable not followed");
endmodule

// File: testbench/rmp_mac_model.sv
// Behavioural MAC driving the transmit side of the RMII port
`timescale 1ns/1ps
module rmp_mac_model (
   output logic o_txd0,
   output logic o_txd1,
   output logic o_txen
);
   // Receive error is never consulted by this MAC
   initial begin
      o_txd0 = 1'b0;
      o_txd1 = 1'b0;
      o_txen = 1'b0;
   end
   // Both lines always carry a dibit; outside frames it is junk
   task drive(input logic [1:0] dib, input logic en);
      o_txd0 = dib[0];
      o_txd1 = dib[1];
      o_txen = en;
   endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench for the RMII port pin logic
`timescale 1ns/1ps
module tb;
   logic       i_core_clk = 1'b0;
   logic       i_sys_rst = 1'b1;
   logic       i_ext_reset_n = 1'b0;
   logic       i_rx_active = 1'b0, i_rx_err = 1'b0;
   logic       i_speed_10 = 1'b0, i_half_duplex = 1'b0;
   logic [1:0] i_rx_dibit = 2'h0;
   logic [3:0] strap = 4'h0;
   logic [1:0] o_tx_dibit;
   logic [4:0] o_pin_pull;
   logic       o_tx_valid, o_rxd0, o_rxd1, o_crs_dv, o_rxer, o_in_reset;
   logic       o_rxd0_oe_n, o_rxd1_oe_n, o_crs_dv_oe_n, o_rxer_oe_n;
   logic       o_opmode_strap_bit0, o_opmode_strap_bit1;
   logic       o_opmode_strap_bit2, o_mgmt_addr_strap_bit0;
   logic       txd0, txd1, txen;
   logic [3:0] straps_got, oe_got;
   logic [15:0] rx_got, rel_got;
   int         n_fail = 0, checks_done = 0, i, k, h;
   // Released pins show the external strap level, else the PHY drive
   wire rxd0_pin = o_rxd0_oe_n ? strap[0] : o_rxd0;
   wire rxd1_pin = o_rxd1_oe_n ? strap[1] : o_rxd1;
   wire crs_pin  = o_crs_dv_oe_n ? strap[2] : o_crs_dv;
   wire rxer_pin = o_rxer_oe_n ? strap[3] : o_rxer;
   assign straps_got = {o_mgmt_addr_strap_bit0, o_opmode_strap_bit2,
                        o_opmode_strap_bit1, o_opmode_strap_bit0};
   assign oe_got = {o_rxer_oe_n, o_crs_dv_oe_n, o_rxd1_oe_n, o_rxd0_oe_n};
   assign rx_got = {12'h000, o_rxer, o_crs_dv, o_rxd1, o_rxd0};
   assign rel_got = {7'h00, o_in_reset, oe_got, straps_got};
   rmp_mac_model mac_u (.o_txd0(txd0), .o_txd1(txd1), .o_txen(txen));
   rmp_rmii_port dut_u (
      .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
      .i_ext_reset_n(i_ext_reset_n), .i_txd0(txd0), .i_txd1(txd1),
      .i_txen(txen), .i_rx_active(i_rx_active), .i_rx_dibit(i_rx_dibit),
      .i_rx_err(i_rx_err), .i_speed_10(i_speed_10),
      .i_half_duplex(i_half_duplex), .i_rxd0_pin(rxd0_pin),
      .i_rxd1_pin(rxd1_pin), .i_crs_dv_pin(crs_pin), .i_rxer_pin(rxer_pin),
      .o_tx_dibit(o_tx_dibit), .o_tx_valid(o_tx_valid), .o_rxd0(o_rxd0),
      .o_rxd0_oe_n(o_rxd0_oe_n), .o_rxd1(o_rxd1), .o_rxd1_oe_n(o_rxd1_oe_n),
      .o_crs_dv(o_crs_dv), .o_crs_dv_oe_n(o_crs_dv_oe_n), .o_rxer(o_rxer),
      .o_rxer_oe_n(o_rxer_oe_n), .o_pin_pull(o_pin_pull),
      .o_in_reset(o_in_reset), .o_opmode_strap_bit0(o_opmode_strap_bit0),
      .o_opmode_strap_bit1(o_opmode_strap_bit1),
      .o_opmode_strap_bit2(o_opmode_strap_bit2),
      .o_mgmt_addr_strap_bit0(o_mgmt_addr_strap_bit0));

   task test_done();
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Expected {rxer, crs_dv, rxd1, rxd0}; b blanks the data lines
   function logic [15:0] exp_rx(input logic [1:0] r, input logic a, x, b);
      exp_rx = {12'h000, x & a, a, (a & ~b) ? r : 2'h0};
   endfunction

   task cyc(input logic [1:0] t, input logic e, input logic [1:0] r,
            input logic a, input logic x, input logic b);
      mac_u.drive(t, e);
      i_rx_dibit = r;
      i_rx_active = a;
      i_rx_err = x;
      @(posedge i_core_clk);
      #1;
      chk(16'({o_tx_valid, o_tx_dibit}), 16'({e, t}));
      chk(rx_got, exp_rx(r, a, x, b));
      @(negedge i_core_clk);
   endtask

   task ext_rst();
      i_ext_reset_n = 1'b0;
      strap = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($urandom);
      repeat (3) @(negedge i_core_clk);
      chk(16'({o_in_reset, oe_got}), 16'h001f);
      i_ext_reset_n = 1'b1;
      repeat (4) @(negedge i_core_clk);
      chk(rel_got, 16'(strap));
      chk(16'(o_pin_pull), 16'h0007);
   endtask

   initial forever #5 i_core_clk = ~i_core_clk;

   initial begin
      void'($urandom(50));
      repeat (20) @(negedge i_core_clk);
      chk(16'({o_tx_valid, o_pin_pull, straps_got}), 16'h0077);
      i_sys_rst = 1'b0;
      for (k = 0; k < 4; k++)
         ext_rst();
      // Fast mode: no blanking, echo is not suppressed
      i_half_duplex = 1'b1;
      for (i = 0; i < 300; i++) begin
         k = $urandom;
         cyc(2'(k), k[2], 2'(k >> 3), k[6:5] != 2'h0, k[7], 1'b0);
      end
      i_speed_10 = 1'b1;
      for (h = 0; h < 2; h++) begin
         i_half_duplex = h[0];
         cyc(2'h0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1);
         for (i = 0; i < 7; i++)
            cyc(2'h1, 1'b0, 2'h1, 1'b1, 1'b0, 1'b1);
         cyc(2'h0, 1'b0, 2'h3, 1'b1, 1'b0, 1'b0);
         for (i = 0; i < 40; i++) begin
            k = $urandom;
            cyc(2'(k), k[2], 2'(k >> 3), 1'b1, k[7], h[0] & k[2]);
         end
         cyc(2'h0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b1);
      end
      k = 2;
      ext_rst();
      test_done();
   end
endmodule
